// >>> vps_pdc_dev_end.sv
// Purpose: decoder end: control byte write and formatted readout of the store
// Assumes: acquisition logic fills the line buffer and flags a checked line
// Notes:   readout bytes are formatted from the store as they are sent
//
// Summary of operation
// RQ1 - answer only the pair chosen by select pin
// RQ2 - write is start, address, control byte, stop
// RQ3 - master releases data; device acks address low
// RQ4 - device acks the control byte low
// RQ5 - control register resets to zero, VPS mode
// RQ6 - software leaves test bits 4-7 unchanged
// RQ7 - bit 1 picks VPS or PDC acquisition
// RQ8 - bit 0 picks format 2 or format 1/header
// RQ9 - bit 2 picks format 1 or header bytes
// RQ10 - bit 3 picks header order A or B
// RQ11 - read returns up to sixteen bytes, MSB first
// RQ12 - every start resets the output byte counter
// RQ13 - after read ack, device drives the byte
// RQ14 - master ack advances counter to next byte
// RQ15 - master no-ack ends transmit, releases data
// RQ16 - master then generates stop, bus free
// RQ17 - format 1: bytes 15-21 then 13, reversed
// RQ18 - VPS: bytes 11-14, each bit-reversed
// RQ19 - format 2: packed nibbles, byte 7 padded ones
// RQ20 - no store update during a link access
// RQ21 - data available goes low on store update
// RQ22 - ignore foreign addresses and extra write bytes
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module vps_pdc_dev_end
  import vps_pdc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  i2c_link_if.dev         link,
  input  wire logic       address_select_pin,
  input  wire logic       line_wr,
  input  wire logic [5:0] line_idx,
  input  wire logic [7:0] line_byte,
  input  wire logic       line_done,
  output logic [7:0]      acquisition_control,
  output logic            data_available_n
);
  dev_state_t  state_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic        rw_reg;
  logic        wr_done_reg;
  logic [4:0]  byte_cnt_reg;
  logic        ack_seen_reg;
  logic        sda_oe_reg;
  logic [7:0]  ctrl_reg;
  logic        data_available_n_reg;
  logic        pend_reg;
  logic        sel_s1_reg;
  logic        sel_s2_reg;
  logic [7:0]  line_reg  [LINE_BYTES];
  logic [7:0]  store_reg [LINE_BYTES];
  logic        sda_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        addr_hit;
  logic        ctrl_wr;
  logic        commit;
  logic        read_acked;
  logic [7:0]  byte_now;

  i2c_line_watch u_watch (
    .mclk      (mclk),
    .srst      (srst),
    .scl_in    (link.scl),
    .sda_in    (link.sda),
    .sda_level (sda_q),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  function automatic logic [7:0] rev8(input logic [7:0] x);
    for (int i = 0; i < BYTE_BITS; i++) begin
      rev8[i] = x[BYTE_BITS - 1 - i];
    end
  endfunction

  // data bits of a protected byte, first-sent data bit on top
  function automatic logic [3:0] hnib(input logic [7:0] x);
    hnib = {x[1], x[3], x[5], x[7]};
  endfunction

  // output byte n of the current mode; past the table the line reads ones
  function automatic logic [7:0] out_byte(input logic [4:0] n);
    int k;
    k = int'(n);
    out_byte = FILL_BYTE;
    if (!ctrl_reg[CTRL_MODE_BIT]) begin
      if (k < VPS_COUNT) out_byte = rev8(store_reg[VPS_FIRST + k]); // RQ18
    end else if (!ctrl_reg[CTRL_FORMAT_BIT]) begin // RQ8
      if (k < F2_PAIR_COUNT) begin // RQ19
        out_byte = {hnib(store_reg[F2_PAIR_FIRST + 2 * k]),
                    hnib(store_reg[F2_PAIR_FIRST + 2 * k + 1])};
      end else if (k == F2_PAIR_COUNT) begin
        out_byte = {hnib(store_reg[F2_B5_SRC]), hnib(store_reg[F2_B5_SRC + 1])};
      end else if (k == F2_PAIR_COUNT + 1) begin
        out_byte = {hnib(store_reg[F2_B6_SRC]), hnib(store_reg[F2_B6_SRC + 1])};
      end else if (k == F2_PAIR_COUNT + 2) begin
        out_byte = {hnib(store_reg[F2_B7_SRC]), NIBBLE_FILL}; // RQ19
      end
    end else if (!ctrl_reg[CTRL_HEADER_BIT]) begin // RQ9
      if (k < F1_COUNT) out_byte = rev8(store_reg[F1_FIRST + k]); // RQ17
      else if (k == F1_COUNT) out_byte = rev8(store_reg[F1_LAST_SRC]); // RQ17
    end else if (ctrl_reg[CTRL_ORDER_BIT]) begin // RQ10
      if (k < HDR_HALF) out_byte = rev8(store_reg[HDR_B_FIRST + k]);
      else if (k < OUT_BYTES) out_byte = rev8(store_reg[HDR_B_SECOND + k - HDR_HALF]);
    end else begin
      if (k < HDR_HALF) out_byte = rev8(store_reg[HDR_A_FIRST + k]);
      else if (k < OUT_BYTES) out_byte = rev8(store_reg[HDR_A_SECOND + k - HDR_HALF]);
    end
  endfunction

  // address pair follows the synchronised select pin
  always_ff @(posedge mclk) begin
    if (srst) begin
      sel_s1_reg <= 1'b0;
      sel_s2_reg <= 1'b0;
    end else begin
      sel_s1_reg <= address_select_pin;
      sel_s2_reg <= sel_s1_reg;
    end
  end

  assign addr_hit   = shift_reg[7:1] == (sel_s2_reg ? DEV_ADDR_HIGH : DEV_ADDR_LOW); // RQ1
  assign ctrl_wr    = (state_reg == DS_WDATA) && scl_fall && (bit_cnt_reg == 4'h8)
                      && !wr_done_reg;
  assign read_acked = (state_reg == DS_ADDR_ACK) && scl_fall && rw_reg;

  // a process, so store and control changes also reach the byte loaded
  always_comb begin
    byte_now = out_byte(byte_cnt_reg);
  end

  // link protocol; data changes only just after the clock falls
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg    <= DS_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      rw_reg       <= 1'b0;
      wr_done_reg  <= 1'b0;
      byte_cnt_reg <= 5'h00;
      ack_seen_reg <= 1'b0;
      sda_oe_reg   <= 1'b0;
    end else if (stop_det) begin
      state_reg  <= DS_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      state_reg    <= DS_ADDR;
      bit_cnt_reg  <= 4'h0;
      byte_cnt_reg <= 5'h00; // RQ12
      wr_done_reg  <= 1'b0;
      sda_oe_reg   <= 1'b0;
    end else begin
      unique case (state_reg)
        DS_IDLE: begin
        end
        DS_ADDR, DS_WDATA: begin
          if (scl_rise && bit_cnt_reg < 4'h8) begin
            shift_reg   <= {shift_reg[6:0], sda_q};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            if (state_reg == DS_ADDR && addr_hit) begin
              sda_oe_reg <= 1'b1; // RQ3
              rw_reg     <= shift_reg[0];
              state_reg  <= DS_ADDR_ACK;
            end else if (state_reg == DS_WDATA && !wr_done_reg) begin
              sda_oe_reg  <= 1'b1; // RQ4
              wr_done_reg <= 1'b1;
              state_reg   <= DS_WACK;
            end else begin
              state_reg <= DS_IDLE; // RQ22
            end
          end
        end
        DS_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              shift_reg  <= byte_now; // RQ13
              sda_oe_reg <= !byte_now[7]; // RQ11
              state_reg  <= DS_TX;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg  <= DS_WDATA;
            end
          end
        end
        DS_WACK: begin
          if (scl_fall) begin
            sda_oe_reg  <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg   <= DS_WDATA;
          end
        end
        DS_TX: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= DS_TX_ACK;
            end else begin
              shift_reg  <= {shift_reg[6:0], 1'b1};
              sda_oe_reg <= !shift_reg[6];
            end
          end
        end
        DS_TX_ACK: begin
          if (scl_rise) begin
            ack_seen_reg <= !sda_q;
            // counter stops past the table so the tail reads as ones
            if (!sda_q && byte_cnt_reg < 5'(OUT_BYTES)) begin
              byte_cnt_reg <= byte_cnt_reg + 5'h01; // RQ14
            end
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (ack_seen_reg) begin
              shift_reg  <= byte_now; // RQ14
              sda_oe_reg <= !byte_now[7];
              state_reg  <= DS_TX;
            end else begin
              state_reg <= DS_IDLE; // RQ15
            end
          end
        end
        default: begin
          state_reg  <= DS_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // only the first byte after the address lands in the control register
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_reg <= CTRL_RESET; // RQ5
    end else if (ctrl_wr) begin
      ctrl_reg <= shift_reg; // RQ7
    end
  end

  // line buffer is written freely; only the store is guarded
  always_ff @(posedge mclk) begin
    if (line_wr && int'(line_idx) < LINE_BYTES) begin
      line_reg[line_idx] <= line_byte;
    end
  end

  // a line finished mid-access waits; set of pending beats the commit
  assign commit = (line_done || pend_reg) && (state_reg == DS_IDLE); // RQ20
  always_ff @(posedge mclk) begin
    if (srst) begin
      pend_reg <= 1'b0;
    end else if (line_done && state_reg != DS_IDLE) begin
      pend_reg <= 1'b1; // RQ20
    end else if (commit) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (commit) begin
      store_reg <= line_reg;
    end
  end

  // low once fresh data sits in the store, high again when a read begins
  always_ff @(posedge mclk) begin
    if (srst) begin
      data_available_n_reg <= 1'b1;
    end else if (commit) begin
      data_available_n_reg <= 1'b0; // RQ21
    end else if (read_acked) begin
      data_available_n_reg <= 1'b1;
    end
  end

  assign link.d_sda_o        = 1'b0;
  assign link.d_sda_oe       = sda_oe_reg;
  assign acquisition_control = ctrl_reg;
  assign data_available_n    = data_available_n_reg;
endmodule
`default_nettype wire

// >>> vps_pdc_pkg.sv
// Purpose: shared constants and state types for the broadcast readout link
// Assumes: 125 MHz mclk, open-drain link lines pulled high by the bench
// Notes:   store indices are packet byte numbers of the acquired line
package vps_pdc_pkg;
  localparam logic [6:0] DEV_ADDR_LOW  = 7'h10;  // write 20h, read 21h
  localparam logic [6:0] DEV_ADDR_HIGH = 7'h11;  // write 22h, read 23h
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam int CTRL_FORMAT_BIT = 0;  // packet_format_select
  localparam int CTRL_MODE_BIT   = 1;  // acquisition_mode_select
  localparam int CTRL_HEADER_BIT = 2;  // header_access_select
  localparam int CTRL_ORDER_BIT  = 3;  // header_order_select
  localparam int OUT_BYTES       = 16;
  localparam int LINE_BYTES      = 46;
  localparam int BYTE_BITS       = 8;
  localparam int VPS_FIRST       = 11;
  localparam int VPS_COUNT       = 4;
  localparam int F1_FIRST        = 15;
  localparam int F1_COUNT        = 7;
  localparam int F1_LAST_SRC     = 13;
  localparam int F2_PAIR_FIRST   = 16;
  localparam int F2_PAIR_COUNT   = 4;
  localparam int F2_B5_SRC       = 14;
  localparam int F2_B6_SRC       = 24;
  localparam int F2_B7_SRC       = 13;
  localparam int HDR_A_FIRST     = 38;
  localparam int HDR_A_SECOND    = 30;
  localparam int HDR_B_FIRST     = 22;
  localparam int HDR_B_SECOND    = 14;
  localparam int HDR_HALF        = 8;
  localparam logic [7:0] FILL_BYTE   = 8'hFF;
  localparam logic [3:0] NIBBLE_FILL = 4'hF;
  localparam int CLK_NS          = 8;
  localparam int SCL_QUARTER_NS  = 40;  // 160 ns link clock, keeps runs short
  localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [6:0] {
    DS_IDLE     = 7'h01,
    DS_ADDR     = 7'h02,
    DS_ADDR_ACK = 7'h04,
    DS_WDATA    = 7'h08,
    DS_WACK     = 7'h10,
    DS_TX       = 7'h20,
    DS_TX_ACK   = 7'h40
  } dev_state_t;
  typedef enum logic [3:0] {
    HS_IDLE  = 4'h1,
    HS_START = 4'h2,
    HS_BIT   = 4'h4,
    HS_STOP  = 4'h8
  } host_state_t;
endpackage

// >>> i2c_link_if.sv
// Purpose: two-wire link between controller and decoder ends
// Assumes: an enable pulls its line low; released lines float high
// Notes:   wired-and is resolved here, never inside the ends
`timescale 1ns/1ns
`default_nettype none
interface i2c_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;
  // open-drain resolution of both lines
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));
  modport host (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
                input scl, input sda);
  modport dev (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

// >>> i2c_line_watch.sv
// Purpose: synchronise both link lines and find clock edges, start, stop
// Assumes: lines idle high; link clock far slower than mclk
// Notes:   events lag the pins by two to three mclk cycles
`timescale 1ns/1ns
`default_nettype none
module i2c_line_watch (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_level,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);
  logic scl_s1_reg;
  logic scl_s2_reg;
  logic scl_p_reg;
  logic sda_s1_reg;
  logic sda_s2_reg;
  logic sda_p_reg;
  // two-stage synchronisers plus one history stage for edges
  always_ff @(posedge mclk) begin
    if (srst) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_p_reg  <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_p_reg  <= 1'b1;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_p_reg  <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_p_reg  <= sda_s2_reg;
    end
  end
  // data moving while the clock stays high marks start or stop
  assign sda_level = sda_s2_reg;
  assign scl_rise  = scl_s2_reg && !scl_p_reg;
  assign scl_fall  = !scl_s2_reg && scl_p_reg;
  assign start_det = scl_s2_reg && scl_p_reg && sda_p_reg && !sda_s2_reg;
  assign stop_det  = scl_s2_reg && scl_p_reg && !sda_p_reg && sda_s2_reg;
endmodule
`default_nettype wire

// >>> vps_pdc_host_end.sv
// Purpose: controller end: control byte writes and multi-byte reads
// Assumes: one command at a time, accepted only while cmd_busy is low
// Notes:   link clock made by quarter-period ticks; no clock stretching
`timescale 1ns/1ns
`default_nettype none
module vps_pdc_host_end
  import vps_pdc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  i2c_link_if.host        link,
  input  wire logic       target_select,
  input  wire logic       cmd_write,
  input  wire logic       cmd_read,
  input  wire logic [7:0] cmd_data,
  input  wire logic [4:0] cmd_count,
  output logic            cmd_busy,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            nack_seen
);
  host_state_t state_reg;
  logic [8:0]  tick_cnt_reg;
  logic [1:0]  phase_reg;
  logic [3:0]  bit_idx_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  rx_reg;
  logic [7:0]  data_reg;
  logic [4:0]  left_reg;
  logic        is_read_reg;
  logic        addr_phase_reg;
  logic        nack_reg;
  logic        scl_oe_reg;
  logic        sda_oe_reg;
  logic        busy_reg;
  logic [7:0]  rd_data_reg;
  logic        rd_valid_reg;
  logic        nack_out_reg;
  logic        sda_q;
  logic        tick;
  logic        receiving;
  logic        more;

  i2c_line_watch u_watch (
    .mclk      (mclk),
    .srst      (srst),
    .scl_in    (link.scl),
    .sda_in    (link.sda),
    .sda_level (sda_q),
    .scl_rise  (),
    .scl_fall  (),
    .start_det (),
    .stop_det  ()
  );

  // quarter-period tick, idle between commands
  assign tick = tick_cnt_reg == 9'(SCL_QUARTER_CYC - 1);
  always_ff @(posedge mclk) begin
    if (srst || state_reg == HS_IDLE || tick) begin
      tick_cnt_reg <= 9'h000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 9'h001;
    end
  end

  assign receiving = is_read_reg && !addr_phase_reg;
  assign more      = left_reg > 5'h01;

  // bit sequencer: drive data, raise clock, sample, drop clock
  always_ff @(posedge mclk) begin
    rd_valid_reg <= 1'b0;
    nack_out_reg <= 1'b0;
    if (srst) begin
      state_reg      <= HS_IDLE;
      phase_reg      <= 2'h0;
      bit_idx_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      rx_reg         <= 8'h00;
      data_reg       <= 8'h00;
      left_reg       <= 5'h00;
      is_read_reg    <= 1'b0;
      addr_phase_reg <= 1'b0;
      nack_reg       <= 1'b0;
      scl_oe_reg     <= 1'b0;
      sda_oe_reg     <= 1'b0;
      busy_reg       <= 1'b0;
      rd_data_reg    <= 8'h00;
    end else begin
      unique case (state_reg)
        HS_IDLE: begin
          if (cmd_write || cmd_read) begin
            is_read_reg    <= cmd_read;
            addr_phase_reg <= 1'b1;
            shift_reg      <= {target_select ? DEV_ADDR_HIGH : DEV_ADDR_LOW, cmd_read};
            data_reg       <= cmd_data;
            left_reg       <= (cmd_count == 5'h00) ? 5'h01 : cmd_count;
            busy_reg       <= 1'b1;
            phase_reg      <= 2'h0;
            state_reg      <= HS_START;
          end
        end
        HS_START: begin
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == 2'h0) sda_oe_reg <= 1'b1;
            else begin
              scl_oe_reg  <= 1'b1;
              phase_reg   <= 2'h0;
              bit_idx_reg <= 4'h0;
              state_reg   <= HS_BIT;
            end
          end
        end
        HS_BIT: begin
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            unique case (phase_reg)
              2'h0: begin
                if (bit_idx_reg < 4'h8) sda_oe_reg <= receiving ? 1'b0 : !shift_reg[7];
                else sda_oe_reg <= receiving && more; // RQ14 RQ15
              end
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: begin
                if (bit_idx_reg < 4'h8) begin
                  rx_reg    <= {rx_reg[6:0], sda_q};
                  shift_reg <= {shift_reg[6:0], 1'b0};
                end else begin
                  nack_reg <= sda_q; // RQ3
                end
              end
              2'h3: begin
                scl_oe_reg  <= 1'b1;
                bit_idx_reg <= bit_idx_reg + 4'h1;
                if (bit_idx_reg == 4'h8) begin
                  bit_idx_reg <= 4'h0;
                  if (receiving) begin
                    rd_valid_reg <= 1'b1;
                    rd_data_reg  <= rx_reg;
                    left_reg     <= left_reg - 5'h01;
                    if (!more) state_reg <= HS_STOP; // RQ16
                  end else if (nack_reg || !addr_phase_reg) begin
                    nack_out_reg <= nack_reg;
                    state_reg    <= HS_STOP; // RQ2
                  end else begin
                    addr_phase_reg <= 1'b0;
                    shift_reg      <= data_reg; // RQ2
                  end
                end
              end
              default: begin
              end
            endcase
          end
        end
        HS_STOP: begin
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            unique case (phase_reg)
              2'h0: sda_oe_reg <= 1'b1;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b0; // RQ16
              2'h3: begin
                busy_reg  <= 1'b0;
                state_reg <= HS_IDLE;
              end
              default: begin
              end
            endcase
          end
        end
        default: state_reg <= HS_IDLE;
      endcase
    end
  end

  assign link.m_scl_o  = 1'b0;
  assign link.m_sda_o  = 1'b0;
  assign link.m_scl_oe = scl_oe_reg;
  assign link.m_sda_oe = sda_oe_reg;
  assign cmd_busy      = busy_reg;
  assign rd_data       = rd_data_reg;
  assign rd_valid      = rd_valid_reg;
  assign nack_seen     = nack_out_reg;
endmodule
`default_nettype wire

// >>> vps_pdc_link_monitor.sv
// Purpose: checks on the wired link between controller and decoder
// Assumes: one mclk domain, srst synchronous active high
// Notes:   sees only the link signals, instantiated beside the link
`timescale 1ns/1ns
`default_nettype none
module vps_pdc_link_monitor (
  input wire logic mclk,
  input wire logic srst,
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_reg;
  logic [3:0] fall_reg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // cycles since the last clock fall, saturating so it never wraps
  always_ff @(posedge mclk) begin
    scl_reg <= scl;
    if (srst) begin
      fall_reg <= 4'hF;
    end else if (scl_reg && !scl) begin
      fall_reg <= 4'h0;
    end else if (fall_reg != 4'hF) begin
      fall_reg <= fall_reg + 4'h1;
    end
  end
  AST_OPEN_DRAIN: assert property (!m_scl_o && !m_sda_o && !d_sda_o)
    else $error("link end drove a high level");
  AST_NO_CLASH: assert property (scl |-> !(m_sda_oe && d_sda_oe))
    else $error("both ends pull data while clock high");
  AST_DEV_STEADY: assert property (scl && $past(scl) |-> $stable(d_sda_oe))
    else $error("device moved data while clock high");
  AST_DEV_EDGE: assert property ($changed(d_sda_oe) |-> fall_reg <= 4'h6)
    else $error("device data change not tied to a clock fall");
  AST_COND_BY_HOST: assert property (scl && $past(scl) && $changed(sda) |-> $changed(m_sda_oe))
    else $error("start or stop not made by the controller");
  AST_IDLE_STOP: assert property (scl && $past(scl) && $rose(sda) |-> !d_sda_oe [*8])
    else $error("device holds data after stop");
  AST_CLK_WIDTH: assert property ($changed(scl) |=> $stable(scl) [*8])
    else $error("link clock phase too short");
  AST_RESET: assert property (disable iff (1'b0) srst |=> !d_sda_oe && !m_sda_oe && !m_scl_oe)
    else $error("link driven during reset");
  cover property (d_sda_oe && scl);
endmodule
`default_nettype wire

// >>> vps_pdc_i2c_slave_readout_tb.sv
// Purpose: end-to-end run of controller and decoder across the link
// Assumes: readout store filled through the line port before reads
// Notes:   one link byte costs about 180 mclk
`timescale 1ns/1ns
`default_nettype none
module vps_pdc_i2c_slave_readout_tb import vps_pdc_pkg::*;;
  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  logic       address_select_pin = 1'b0;
  logic       target_select = 1'b0;
  logic       line_wr = 1'b0;
  logic [5:0] line_idx = 6'h00;
  logic [7:0] line_byte = 8'h00;
  logic       line_done = 1'b0;
  logic       cmd_write = 1'b0;
  logic       cmd_read = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic [4:0] cmd_count = 5'h00;
  logic [7:0] acquisition_control;
  logic       data_available_n;
  logic       cmd_busy;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic       nack_seen;
  logic [7:0] store [0:45];
  logic [7:0] exp_q [$];
  int         nack_cnt = 0;
  int         miscompares = 0;
  int         check_count = 0;
  i2c_link_if link ();
  vps_pdc_dev_end u_vps_pdc_dev_end (
    .mclk(mclk), .srst(srst), .link(link), .address_select_pin(address_select_pin),
    .line_wr(line_wr), .line_idx(line_idx), .line_byte(line_byte), .line_done(line_done),
    .acquisition_control(acquisition_control), .data_available_n(data_available_n));
  vps_pdc_host_end u_vps_pdc_host_end (
    .mclk(mclk), .srst(srst), .link(link), .target_select(target_select),
    .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_data(cmd_data), .cmd_count(cmd_count),
    .cmd_busy(cmd_busy), .rd_data(rd_data), .rd_valid(rd_valid), .nack_seen(nack_seen));
  vps_pdc_link_monitor u_vps_pdc_link_monitor (
    .mclk(mclk), .srst(srst), .m_scl_o(link.m_scl_o), .m_scl_oe(link.m_scl_oe),
    .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe), .d_sda_o(link.d_sda_o),
    .d_sda_oe(link.d_sda_oe), .scl(link.scl), .sda(link.sda));
  always #4 mclk = ~mclk;
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch at %0t: seen %0h want %0h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic logic [7:0] rev(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rev[i] = b[7 - i];
    end
  endfunction
  // data bits of a protected byte, first-sent data bit on top
  function automatic logic [3:0] nib(input logic [7:0] b);
    return {b[1], b[3], b[5], b[7]};
  endfunction
  // one line buffer write, then a one-cycle line_done pulse; two cycles long
  task automatic put(input logic [5:0] idx, input logic [7:0] val);
    line_wr   <= 1'b1;
    line_idx  <= idx;
    line_byte <= val;
    @(posedge mclk);
    line_wr   <= 1'b0;
    line_done <= 1'b1;
    @(posedge mclk);
    line_done <= 1'b0;
  endtask
  // strobe one command, then wait out busy; extra edges let busy land
  task automatic run_cmd(input logic wr, input logic [7:0] data, input logic [4:0] cnt);
    cmd_write <= wr;
    cmd_read  <= !wr;
    cmd_data  <= data;
    cmd_count <= cnt;
    @(posedge mclk);
    cmd_write <= 1'b0;
    cmd_read  <= 1'b0;
    repeat (3) @(posedge mclk);
    while (cmd_busy !== 1'b0) begin
      @(posedge mclk);
    end
  endtask
  // expectations are noted before the read is launched
  task automatic read_bytes(input int first, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      exp_q.push_back(rev(store[first + i]));
    end
    run_cmd(1'b0, 8'h00, 5'(cnt));
  endtask
  // oldest note against each received byte; empty queue pops unknown
  always @(posedge mclk) begin
    if (rd_valid === 1'b1) begin
      check(rd_data, exp_q.pop_front());
    end
    if (nack_seen === 1'b1) begin
      nack_cnt++;
    end
  end
  initial begin
    #(20000 * 8);
    miscompares++;
    close_out();
  end
  initial begin
    void'($urandom(83222));
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    check(acquisition_control, CTRL_RESET);
    check({7'h00, data_available_n}, 8'h01);
    $display("reset test done");
    // whole line of random bytes, each write also commits it
    for (int i = 0; i < LINE_BYTES; i++) begin
      store[i] = 8'($urandom());
      put(6'(i), store[i]);
    end
    repeat (3) @(posedge mclk);
    check({7'h00, data_available_n}, 8'h00);
    $display("fill test done");
    address_select_pin <= 1'b1;
    target_select      <= 1'b1;
    read_bytes(VPS_FIRST, 2);
    check({7'h00, data_available_n}, 8'h01);
    check(8'(nack_cnt), 8'h00);
    $display("vps read done");
    address_select_pin <= 1'b0;
    run_cmd(1'b0, 8'h00, 5'h01);
    check(8'(nack_cnt), 8'h01);
    $display("foreign address done");
    target_select <= 1'b0;
    run_cmd(1'b1, 8'h03, 5'h00);
    check(acquisition_control, 8'h03);
    check(8'(nack_cnt), 8'h01);
    $display("control write done");
    // new line arrives mid-read: readout must keep the old byte
    fork
      read_bytes(F1_FIRST, 1);
      begin
        repeat (100) @(posedge mclk);
        put(6'h0F, ~store[F1_FIRST]);
      end
    join
    store[F1_FIRST] = ~store[F1_FIRST];
    repeat (4) @(posedge mclk);
    check({7'h00, data_available_n}, 8'h00);
    check(8'(exp_q.size()), 8'h00);
    $display("format one read done");
    run_cmd(1'b1, 8'h02, 5'h00);
    for (int i = 16; i < 24; i += 2) begin
      exp_q.push_back({nib(store[i]), nib(store[i + 1])});
    end
    exp_q.push_back({nib(store[14]), nib(store[15])});
    exp_q.push_back({nib(store[24]), nib(store[25])});
    exp_q.push_back({nib(store[13]), 4'hF});
    run_cmd(1'b0, 8'h00, 5'h07);
    $display("format two read done");
    run_cmd(1'b1, 8'h07, 5'h00);
    for (int i = 0; i < 16; i++) begin
      exp_q.push_back(rev(store[i < 8 ? 38 + i : 22 + i]));
    end
    run_cmd(1'b0, 8'h00, 5'h10);
    run_cmd(1'b1, 8'h0F, 5'h00);
    read_bytes(HDR_B_FIRST, 8);
    check(8'(exp_q.size()), 8'h00);
    $display("header read done");
    close_out();
  end
endmodule
`default_nettype wire
